// ==== hw/qvl_pkg.sv ====
// shared constants for the quad converter serial loader
package qvl_pkg;

  // frame layout: four enable bits first, twelve code bits after
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 12;
  localparam int unsigned NUM_CONV = 4;
  localparam int unsigned ADDR_LSB = 12;
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned DATA_LSB = 0;
  localparam int unsigned DATA_MSB = 11;
  localparam logic [3:0]  LAST_BIT = 4'hF;

  // values after reset
  localparam logic [11:0] CODE_RESET  = 12'h000;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [3:0]  COUNT_RESET = 4'h0;

  // timing
  localparam int unsigned SYS_CLK_HZ       = 10_000_000;
  localparam int unsigned SYS_PERIOD_NS    = 100;
  localparam int unsigned SCLK_MAX_HZ      = 20_000_000;
  localparam int unsigned SYNC_HIGH_MIN_NS = 50;
  // least time rounds up, never below one cycle
  localparam int unsigned SYNC_HIGH_RAW    = (SYNC_HIGH_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned SYNC_HIGH_CYC    = (SYNC_HIGH_RAW < 1) ? 1 : SYNC_HIGH_RAW;
  // half period of the serial clock in system cycles, kept under the maximum rate
  localparam int unsigned DIV_HALF_RAW     = (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int unsigned DIV_HALF_CYC     = (DIV_HALF_RAW < 1) ? 1 : DIV_HALF_RAW;
  localparam logic [3:0]  DIV_LAST         = 4'(DIV_HALF_CYC - 1);
  localparam logic [3:0]  GAP_LAST         = 4'(SYNC_HIGH_CYC - 1);

endpackage

// ==== hw/qvl_link_if.sv ====
// three-wire serial link between the host port and the converter loader
`timescale 1ns/100ps
`default_nettype none

interface qvl_link_if;
  logic frame_n; // active-low frame sync
  logic sclk;    // serial clock, made by the host
  logic sdata;   // serial data, msb first

  modport host (
    output frame_n,
    output sclk,
    output sdata
  );

  modport dev (
    input frame_n,
    input sclk,
    input sdata
  );
endinterface

`default_nettype wire

// ==== hw/qvl_dev.sv ====
// converter end: serial shift port on the link clock, converter code registers on the system clock
`timescale 1ns/100ps
`default_nettype none

module qvl_dev
  import qvl_pkg::*;
(
  input  wire logic                           sys_clk_in,
  input  wire logic                           nrst_in,
  input  wire logic                           en_in,
  qvl_link_if.dev                             lnk,
  output logic      [NUM_CONV-1:0][DATA_W-1:0] code_out,
  output logic      [ADDR_W-1:0]              last_addr_out,
  output logic                                update_out,
  output logic                                abort_out
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: clocked by falling edges of the serial clock

  logic              lrst_meta;
  logic              lrst_n;
  logic              lrst_req_n;
  logic [1:0]        lack_sync;
  logic [WORD_W-1:0] shift_reg;
  logic [3:0]        bit_cnt;
  logic              armed;
  logic [WORD_W-1:0] word;
  logic              done_tog;
  logic              abort_tog;

  // link reset request brought into the link domain through two flops
  always_ff @(negedge lnk.sclk) begin
    lrst_meta <= lrst_req_n;
    lrst_n    <= lrst_meta;
  end

  // next shift contents, newest bit at the bottom
  wire [WORD_W-1:0] next_shift = {shift_reg[WORD_W-2:0], lnk.sdata};
  wire              last_edge  = (bit_cnt == LAST_BIT);
  wire              shifting   = armed & ~lnk.frame_n;
  wire              early_rise = lnk.frame_n & armed & (bit_cnt != COUNT_RESET);

  // shift register, bit counter and arming on a seen-high sync
  always_ff @(negedge lnk.sclk) begin
    if (!lrst_n) begin
      shift_reg <= WORD_RESET;
      bit_cnt   <= COUNT_RESET;
      armed     <= 1'b0;
      word      <= WORD_RESET;
      done_tog  <= 1'b0;
      abort_tog <= 1'b0;
    end else if (lnk.frame_n) begin
      shift_reg <= WORD_RESET;
      bit_cnt   <= COUNT_RESET;
      armed     <= 1'b1;
      if (early_rise) begin
        abort_tog <= ~abort_tog;
      end
    end else if (shifting) begin
      shift_reg <= next_shift;
      if (last_edge) begin
        word     <= next_shift;
        done_tog <= ~done_tog;
        armed    <= 1'b0;
        bit_cnt  <= COUNT_RESET;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: event crossing by toggle and two-flop synchroniser

  logic [1:0] done_sync;
  logic       done_prev;
  logic [1:0] abort_sync;
  logic       abort_prev;

  // the serial clock may stand still while the system reset is held, so the
  // link reset request stays low until the link side is seen in reset
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      lrst_req_n <= 1'b0;
      lack_sync  <= 2'h0;
    end else if (en_in) begin
      lack_sync <= {lack_sync[0], ~lrst_n};
      if (lack_sync[1]) begin
        lrst_req_n <= 1'b1;
      end
    end
  end

  // done_sync[0] and abort_sync[0] feed only the second stage;
  // toggles are followed only once the link side has been reset
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      done_sync  <= 2'h0;
      done_prev  <= 1'b0;
      abort_sync <= 2'h0;
      abort_prev <= 1'b0;
    end else if (en_in && lrst_req_n) begin
      done_sync  <= {done_sync[0], done_tog};
      done_prev  <= done_sync[1];
      abort_sync <= {abort_sync[0], abort_tog};
      abort_prev <= abort_sync[1];
    end
  end

  // a toggle edge marks a finished or aborted frame; word is stable by then
  wire              load_evt  = done_sync[1] ^ done_prev;
  wire              abort_evt = abort_sync[1] ^ abort_prev;
  wire [ADDR_W-1:0] frame_addr = word[ADDR_MSB:ADDR_LSB];
  wire [DATA_W-1:0] frame_code = word[DATA_MSB:DATA_LSB];

  // strobes and the last address seen
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      update_out    <= 1'b0;
      abort_out     <= 1'b0;
      last_addr_out <= {ADDR_W{1'b0}};
    end else if (en_in) begin
      update_out <= load_evt;
      abort_out  <= abort_evt;
      if (load_evt) begin
        last_addr_out <= frame_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter code registers, one per address bit

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
      // the code is stored as plain unsigned binary, whole range kept
      wire hit = load_evt & frame_addr[gi];
      always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
          code_out[gi] <= CODE_RESET;
        end else if (en_in && hit) begin
          code_out[gi] <= frame_code;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // notes for users of this end
  //
  // the link domain sees the sync level only at falling serial clock edges,
  // so a frame start needs one falling edge with sync high before the first
  // data edge; the host keeps the serial clock running for that reason.
  //
  // once the sixteenth edge has executed, the frame is disarmed: sync may stay
  // low with the clock running and nothing more is shifted until sync has been
  // seen high again.
  //
  // an aborted frame never touches the stored word, so the system domain only
  // reports the abort and leaves every converter code as it was.
  //
  // the captured word stays put for at least sixteen serial clock periods,
  // which covers the three system cycles the crossing needs to pick it up.
  //
  // the clock enable freezes only the system domain; the link domain is owned
  // by the serial clock and cannot be held from the system side safely.
  //
  // with several address bits set one frame loads the same code into each
  // enabled converter in the same system cycle.
  //
  // with no address bit set the frame still completes and pulses update_out,
  // but no converter code changes.
  //
  // the converter reference voltage scales the analogue output outside this
  // logic: output equals converter_reference_voltage times code over 4096.
  //
  // the link domain is reset through a request that the system side holds
  // until the link side answers, so the serial clock may stop during reset;
  // frames are taken only about a dozen system cycles after reset is released.
  //
  // there is no read-back path; last_addr_out and update_out show what the
  // most recent complete frame did.
  //
  // abort_out flags a frame cut short after at least one bit was taken; a
  // sync pulse with no bits shifted is not counted as an abort.
  //
  // the counter wraps to zero on the sixteenth edge, so the next frame can
  // follow as soon as sync has risen and fallen again.
  //
  // the shift register is cleared whenever sync is seen high, not only on an
  // abort, so stale bits never leak into the next frame.
  //
  // sampling, counting and capture share one clock edge; data must be set up
  // by the host before each falling edge and held a little after it.
  ////////////////////////////////////////////////////////////////////////////

endmodule

`default_nettype wire

// ==== hw/qvl_host.sv ====
// host end: divides the system clock into the serial clock and sends one 16-bit frame per request
`timescale 1ns/100ps
`default_nettype none

module qvl_host
  import qvl_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              nrst_in,
  input  wire logic              en_in,
  input  wire logic              start_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] code_in,
  input  wire logic              abort_in,
  qvl_link_if.host               lnk,
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   aborted_out
);

  typedef enum logic [1:0] {QVL_IDLE, QVL_SHIFT, QVL_GAP} qvl_state_e;

  qvl_state_e        state;
  logic [3:0]        div_cnt;
  logic              sclk_q;
  logic              frame_n_q;
  logic              sdata_q;
  logic [WORD_W-1:0] shift_reg;
  logic [3:0]        bit_cnt;
  logic [3:0]        gap_cnt;
  logic              pend;
  logic              cut_req;

  ////////////////////////////////////////////////////////////////////////////
  // clock divider: free running, a tick flips the serial clock
  wire tick = (div_cnt == DIV_LAST);
  wire rise = tick & ~sclk_q;
  wire fall = tick & sclk_q;
  wire gap_ok = (gap_cnt == GAP_LAST);

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      div_cnt <= 4'h0;
      sclk_q  <= 1'b0;
    end else if (en_in) begin
      div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
      if (tick) begin
        sclk_q <= ~sclk_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer: data and sync change on rising edges, device samples on
  // falling ones; sync idles high, the low-power low idle is not used
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state       <= QVL_IDLE;
      frame_n_q   <= 1'b1;
      sdata_q     <= 1'b0;
      shift_reg   <= WORD_RESET;
      bit_cnt     <= COUNT_RESET;
      gap_cnt     <= 4'h0;
      pend        <= 1'b0;
      cut_req     <= 1'b0;
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      aborted_out <= 1'b0;
    end else if (en_in) begin
      done_out    <= 1'b0;
      aborted_out <= 1'b0;
      unique case (state)
        QVL_IDLE: begin
          if (start_in && !pend) begin
            pend      <= 1'b1;
            busy_out  <= 1'b1;
            shift_reg <= {addr_in, code_in};
          end
          if (pend && rise) begin
            frame_n_q <= 1'b0;
            sdata_q   <= shift_reg[WORD_W-1];
            shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
            bit_cnt   <= COUNT_RESET;
            pend      <= 1'b0;
            cut_req   <= 1'b0;
            state     <= QVL_SHIFT;
          end
        end
        QVL_SHIFT: begin
          if (abort_in) begin
            cut_req <= 1'b1;
          end
          if (rise) begin
            sdata_q   <= shift_reg[WORD_W-1];
            shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
          end
          if (fall) begin
            if (bit_cnt == LAST_BIT) begin
              done_out  <= 1'b1;
              gap_cnt   <= 4'h0;
              state     <= QVL_GAP;
            end else if (cut_req || abort_in) begin
              aborted_out <= 1'b1;
              gap_cnt     <= 4'h0;
              state       <= QVL_GAP;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        QVL_GAP: begin
          // sync rises on a serial clock rise, clear of the sampling edge,
          // then stays high for the least time and across one falling edge
          if (!frame_n_q) begin
            if (rise) begin
              frame_n_q <= 1'b1;
            end
          end else begin
            if (!gap_ok) begin
              gap_cnt <= gap_cnt + 4'h1;
            end
            if (fall && gap_ok) begin
              busy_out <= 1'b0;
              state    <= QVL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // link pins straight from flops
  assign lnk.sclk    = sclk_q;
  assign lnk.frame_n = frame_n_q;
  assign lnk.sdata   = sdata_q;

endmodule

`default_nettype wire

// ==== test/qvl_props.sv ====
// checker for the serial link between the host end and the converter end
`timescale 1ns/100ps
`default_nettype none

module qvl_props (
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  input  wire logic frame_n,
  input  wire logic sclk,
  input  wire logic busy_out,
  input  wire logic done_out,
  input  wire logic aborted_out,
  input  wire logic update_out,
  input  wire logic abort_out
);
  // sixteen falling edges at two cycles a bit span 31 sampled low cycles
  localparam int MIN_LOW = 31;

  logic       frame_q;
  logic [7:0] low_len;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////////////////////////////////////
  // length of the current or last low period of frame sync
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      frame_q <= 1'b1;
      low_len <= 8'h00;
    end else begin
      frame_q <= frame_n;
      if (!frame_n) begin
        low_len <= frame_q ? 8'h01 : low_len + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link relations
  AST_FALL_ON_RISE: assert property ($fell(frame_n) |-> sclk)
    else $error("frame sync fell away from a serial clock rise");
  AST_IDLE_HIGH: assert property (!busy_out |-> frame_n)
    else $error("frame sync low while host idle");
  AST_LOW_LEN: assert property (done_out |-> low_len >= MIN_LOW)
    else $error("frame completed with sync low too short");
  AST_DONE_UPDATE: assert property (done_out |-> ##[1:8] update_out)
    else $error("complete frame not executed in time");
  AST_UPD_SINGLE: assert property (update_out |=> (!update_out) [*8])
    else $error("more than one update for one word");
  AST_ABORT_FLAG: assert property (aborted_out |-> ##[0:8] abort_out)
    else $error("cut frame not flagged by converter end");
  AST_ABORT_NO_UPD: assert property (aborted_out |-> (!update_out) [*8])
    else $error("cut frame caused an update");
  AST_SYNC_GAP: assert property ($rose(frame_n) |-> frame_n [*2])
    else $error("frame sync high gap too short");
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench: host end and converter end joined over the serial link
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import qvl_pkg::*;
;
  logic                            sys_clk;
  logic                            nrst;
  logic                            en;
  logic                            start;
  logic                            cut;
  logic [ADDR_W-1:0]               addr;
  logic [DATA_W-1:0]               code;
  logic                            busy;
  logic                            done;
  logic                            aborted;
  logic                            update;
  logic                            abort_seen;
  logic [ADDR_W-1:0]               last_addr;
  logic [NUM_CONV-1:0][DATA_W-1:0] code_w;
  logic [NUM_CONV-1:0][DATA_W-1:0] exp_code;
  int                              miscompares;
  int                              num_checks;
  int                              upd_cnt;
  int                              abt_cnt;

  ////////////////////////////////////////////////////////////////////////
  // clock, link and the two ends
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  qvl_link_if lnk_if ();

  qvl_host i_qvl_host (.sys_clk_in(sys_clk), .nrst_in(nrst), .en_in(en), .start_in(start), .addr_in(addr),
    .code_in(code), .abort_in(cut), .lnk(lnk_if), .busy_out(busy), .done_out(done), .aborted_out(aborted));

  qvl_dev i_qvl_dev (.sys_clk_in(sys_clk), .nrst_in(nrst), .en_in(en), .lnk(lnk_if), .code_out(code_w),
    .last_addr_out(last_addr), .update_out(update), .abort_out(abort_seen));

  qvl_props i_qvl_props (.sys_clk_in(sys_clk), .nrst_in(nrst), .frame_n(lnk_if.frame_n), .sclk(lnk_if.sclk),
    .busy_out(busy), .done_out(done), .aborted_out(aborted), .update_out(update), .abort_out(abort_seen));

  // count converter-end strobes
  always @(posedge sys_clk) begin
    if (update === 1'b1) upd_cnt++;
    if (abort_seen === 1'b1) abt_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic fail(input string msg);
    miscompares++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_codes;
    for (int i = 0; i < NUM_CONV; i++) begin
      num_checks++;
      if (code_w[i] !== exp_code[i]) fail("converter code mismatch");
    end
  endtask

  // one host request, optionally cut after a few bits, then judged
  task automatic frame(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] c, input bit stop);
    int n;
    int u0;
    int b0;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    num_checks++;
    if (lnk_if.frame_n !== 1'b1) fail("sync not idle high");
    u0 = upd_cnt;
    b0 = abt_cnt;
    @(posedge sys_clk);
    addr <= a;
    code <= c;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    if (stop) begin
      repeat (12) @(posedge sys_clk);
      cut <= 1'b1;
    end
    while (done !== 1'b1 && aborted !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cut <= 1'b0;
    repeat (12) @(negedge sys_clk);
    if (n >= 200) begin
      fail("frame timed out");
      wrap_up;
    end
    for (int i = 0; i < NUM_CONV; i++) begin
      if (!stop && a[i]) exp_code[i] = c;
    end
    num_checks++;
    if (stop && (upd_cnt != u0 || abt_cnt != b0 + 1)) fail("cut frame mishandled");
    if (!stop && (upd_cnt != u0 + 1 || last_addr !== a)) fail("word not executed");
    check_codes;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power_on;
    check_codes;
    frame(4'h0, 12'hFFF, 1'b0);
  endtask

  task automatic t_each_conv;
    logic [DATA_W-1:0] pat [NUM_CONV] = '{12'hFFF, 12'h801, 12'h001, 12'hA5C};
    for (int i = 0; i < NUM_CONV; i++) begin
      frame(4'h1 << i, pat[i], 1'b0);
    end
  endtask

  task automatic t_group_write;
    frame(4'hF, 12'h000, 1'b0);
    frame(4'hA, 12'hFFF, 1'b0);
  endtask

  task automatic t_cut_then_next;
    frame(4'hF, 12'h7E7, 1'b1);
    frame(4'h5, 12'h3C7, 1'b0);
  endtask

  // reset in mid-run: codes clear and the link comes back up
  task automatic t_reset_again;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (40) @(posedge sys_clk);
    exp_code = '0;
    check_codes;
    frame(4'h9, 12'h5A3, 1'b0);
  endtask

  // main sequence
  initial begin
    en = 1'b1;
    start = 1'b0;
    cut = 1'b0;
    addr = '0;
    code = '0;
    exp_code = '0;
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (40) @(posedge sys_clk);
    t_power_on;
    t_each_conv;
    t_group_write;
    t_cut_then_next;
    t_reset_again;
    wrap_up;
  end
endmodule

`default_nettype wire
